// *** dv/periph_model.sv ***
`timescale 1ns/1ns

// ------------------------------------------------------------
// Peripherals on the far side of the flag block
// ------------------------------------------------------------
module periph_model (
  // Clock
  input  wire logic        pclk,
  // Event lines and serial unit state
  output logic      [14:0] evt,
  output logic      [7:0]  s4_irq,
  output logic      [7:0]  s4_err,
  output logic      [7:0]  s5_irq,
  output logic      [7:0]  s5_err,
  output logic      [3:0]  txrx
);
  // Quiet peripherals from time zero
  initial begin
    evt    = 15'h0000;
    s4_irq = 8'h00;
    s4_err = 8'h00;
    s5_irq = 8'h00;
    s5_err = 8'h00;
    txrx   = 4'h0;
  end

  // One-cycle event pulse, raised with no enable involved
  task automatic pulse(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
  endtask

  // Serial unit status, driven whole on one clock edge to the values given
  task automatic serial(input int u, input logic [7:0] iv, ev,
                        input logic [1:0] tr);
    @(posedge pclk);
    if (u == 0) begin
      s4_irq     <= iv;
      s4_err     <= ev;
      txrx[3:2]  <= tr;
    end else begin
      s5_irq     <= iv;
      s5_err     <= ev;
      txrx[1:0]  <= tr;
    end
  endtask
endmodule // periph_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, txrx;
  logic [14:0] evt;
  logic [7:0]  s4_irq, s4_err, s5_irq, s5_err;
  logic [7:0]  irq_request_12, irq_request_13, irq_request_14;
  logic [7:0]  irq_request_15;
  logic [7:0]  exp_img [4];
  logic        err;
  int          fails, n_tests;

  // ------------------------------------------------------------
  // Design and peripherals
  // ------------------------------------------------------------
  periph_irq_flags periph_irq_flags_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_ch5_abort_evt(evt[0]), .dma_ch5_overrun_evt(evt[1]),
    .dma_ch5_dest_count_evt(evt[2]), .dma_ch5_src_count_evt(evt[3]),
    .dma_ch6_abort_evt(evt[4]), .dma_ch6_overrun_evt(evt[5]),
    .dma_ch6_dest_count_evt(evt[6]), .dma_ch6_src_count_evt(evt[7]),
    .serial4_irq_status(s4_irq), .serial4_error_status(s4_err),
    .serial4_tx_req(txrx[3]), .serial4_rx_req(txrx[2]),
    .serial5_irq_status(s5_irq), .serial5_error_status(s5_err),
    .serial5_tx_req(txrx[1]), .serial5_rx_req(txrx[0]),
    .osc3_evt(evt[8]), .comparator2_evt(evt[9]),
    .logic_cell7_evt(evt[10]), .timer6_evt(evt[11]),
    .checksum_evt(evt[12]), .logic_cell8_evt(evt[13]),
    .nonvolatile_evt(evt[14]),
    .irq_request_12(irq_request_12), .irq_request_13(irq_request_13),
    .irq_request_14(irq_request_14), .irq_request_15(irq_request_15),
    .irq(irq)
  );

  periph_model periph_model_inst (
    .pclk(pclk), .evt(evt), .s4_irq(s4_irq), .s4_err(s4_err),
    .s5_irq(s5_irq), .s5_err(s5_err), .txrx(txrx)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high or 20 access cycles pass
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      check({31'h0, pready}, 32'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Flag image port of one request register
  function automatic logic [7:0] img(input int r);
    case (r)
      0:       return irq_request_12;
      1:       return irq_request_13;
      2:       return irq_request_14;
      default: return irq_request_15;
    endcase
  endfunction

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask

  function automatic logic [15:0] req_addr(input int r);
    return 16'h12e8 + 16'(4 * r);
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int r = 0; r < 4; r++)
      rd_chk(req_addr(r), 8'h00);
    rd_chk(16'h1300, 8'h00);
    rd_chk(16'h1304, 8'h00);
    apb(1'b0, 16'h1000, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  // Every event lands in its own bit and stays until written clear
  task automatic t_events;
    int r;
    int b;
    for (int r0 = 0; r0 < 4; r0++)
      exp_img[r0] = 8'h00;
    for (int i = 0; i < 15; i++) begin
      r = (i < 8) ? i / 4 : ((i < 11) ? 2 : 3);
      b = (i < 8) ? 7 - i % 4 : ((i < 11) ? 11 - i : 14 - i);
      periph_model_inst.pulse(i);
      wait_cyc(2);
      exp_img[r][b] = 1'b1;
      check({24'h0, img(r)}, {24'h0, exp_img[r]});
      rd_chk(req_addr(r), exp_img[r]);
    end
    wait_cyc(10);
    for (r = 0; r < 4; r++) begin
      rd_chk(req_addr(r), exp_img[r]);
      apb(1'b1, req_addr(r), 8'h00);
      rd_chk(req_addr(r), 8'h00);
    end
  endtask

  // Serial flags mirror the unit; software writes have no effect
  task automatic t_serial;
    for (int u = 0; u < 2; u++) begin
      periph_model_inst.serial(u, 8'h06, 8'h00, 2'b10);
      wait_cyc(3);
      apb(1'b1, req_addr(u), 8'h05);
      rd_chk(req_addr(u), 8'h0a);
      periph_model_inst.serial(u, 8'h04, 8'h00, 2'b10);
      wait_cyc(3);
      rd_chk(req_addr(u), 8'h0a);
      periph_model_inst.serial(u, 8'h00, 8'h80, 2'b01);
      wait_cyc(3);
      apb(1'b1, req_addr(u), 8'h0a);
      rd_chk(req_addr(u), 8'h05);
      periph_model_inst.serial(u, 8'h00, 8'h00, 2'b00);
      wait_cyc(3);
      rd_chk(req_addr(u), 8'h00);
    end
  endtask

  // Event on the very edge of a clearing write survives it
  task automatic t_race;
    periph_model_inst.pulse(0);
    wait_cyc(2);
    fork
      apb(1'b1, req_addr(0), 8'h00);
      begin
        @(posedge pclk);
        periph_model_inst.pulse(1);
      end
    join
    rd_chk(req_addr(0), 8'h40);
    apb(1'b1, req_addr(0), 8'h00);
  endtask

  // Summary interrupt: raised, masked, cleared by reading status
  task automatic t_irq;
    for (int r = 0; r < 4; r++)
      apb(1'b1, req_addr(r), 8'h00);
    apb(1'b0, 16'h1300, 8'h00);
    apb(1'b1, 16'h1304, 8'h01);
    rd_chk(16'h1304, 8'h01);
    wait_cyc(1);
    check({31'h0, irq}, 32'h0);
    periph_model_inst.pulse(14);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    periph_model_inst.pulse(0);
    wait_cyc(3);
    check({31'h0, irq}, 32'h1);
    rd_chk(16'h1300, 8'h09);
    wait_cyc(2);
    check({31'h0, irq}, 32'h0);
    rd_chk(16'h1300, 8'h00);
    // Write with its byte strobe low leaves the flags alone
    pstrb <= 4'h0;
    apb(1'b1, req_addr(0), 8'h00);
    pstrb <= 4'hf;
    rd_chk(req_addr(0), 8'h80);
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    fails   = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_serial();
    t_race();
    t_irq();
    report_and_stop();
  end

  initial begin
    #3000000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // tb_top

// *** rtl/irq_flag_cfg.svh ***
`ifndef IRQ_FLAG_CFG_SVH
`define IRQ_FLAG_CFG_SVH

// ------------------------------------------------------------
// Register indices (word index, byte address is index times 4)
// ------------------------------------------------------------
`define IDX_REQ12       14'h04ba
`define IDX_REQ13       14'h04bb
`define IDX_REQ14       14'h04bc
`define IDX_REQ15       14'h04bd
`define IDX_IRQ_STATUS  14'h04c0
`define IDX_IRQ_MASK    14'h04c1

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_DMA_ABORT    7
`define BIT_DMA_OVERRUN  6
`define BIT_DMA_DEST     5
`define BIT_DMA_SRC      4
`define BIT_SER_SUMMARY  3
`define BIT_SER_ERROR    2
`define BIT_SER_TX       1
`define BIT_SER_RX       0

// ------------------------------------------------------------
// Hardware-set flag layout per request byte (12,13,14,15)
// ------------------------------------------------------------
`define HW_FLAG_MAP      32'h0f0e_f0f0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_REQ          8'h00
`define RST_IRQ_STATUS   4'h0
`define RST_IRQ_MASK     4'h0

`endif

// *** rtl/irq_flag_pkg.sv ***
package irq_flag_pkg;

  `include "irq_flag_cfg.svh"

  // Byte-wide flag image
  typedef logic [7:0] flag_byte_t;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_REQ12  = 3'b001,
    SEL_REQ13  = 3'b010,
    SEL_REQ14  = 3'b011,
    SEL_REQ15  = 3'b100,
    SEL_STATUS = 3'b101,
    SEL_MASK   = 3'b110
  } reg_sel_t;

  // Address decode, used by read and write paths
  function automatic reg_sel_t decode_addr(input logic [15:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      {`IDX_REQ12, 2'b00}:      sel = SEL_REQ12;
      {`IDX_REQ13, 2'b00}:      sel = SEL_REQ13;
      {`IDX_REQ14, 2'b00}:      sel = SEL_REQ14;
      {`IDX_REQ15, 2'b00}:      sel = SEL_REQ15;
      {`IDX_IRQ_STATUS, 2'b00}: sel = SEL_STATUS;
      {`IDX_IRQ_MASK, 2'b00}:   sel = SEL_MASK;
      default:                  sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// *** rtl/irq_status_mask.sv ***
`timescale 1ns/1ns
`include "irq_flag_cfg.svh"

module irq_status_mask (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Events and read clear
  input  wire logic [3:0] event_in,
  input  wire logic [3:0] read_clear,
  // Mask write
  input  wire logic       mask_wr,
  input  wire logic [3:0] mask_data,
  // State and interrupt
  output logic      [3:0] status,
  output logic      [3:0] mask,
  output logic            irq
);

  logic [3:0] next_status;
  logic [3:0] next_mask;

  // Sticky status, set wins over read clear
  always_comb begin
    next_status = (status & ~read_clear) | event_in;
    next_mask   = mask_wr ? mask_data : mask;
  end

  // Status, mask and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `RST_IRQ_STATUS;
      mask   <= `RST_IRQ_MASK;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= |(next_status & next_mask);
    end
  end

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn) irq == |(status & mask))
    else $error("interrupt level disagrees with status and mask");

endmodule // irq_status_mask

// *** rtl/periph_irq_flags.sv ***
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "irq_flag_cfg.svh"

module periph_irq_flags
  import irq_flag_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // DMA channel 5 events
  input  wire logic        dma_ch5_abort_evt,
  input  wire logic        dma_ch5_overrun_evt,
  input  wire logic        dma_ch5_dest_count_evt,
  input  wire logic        dma_ch5_src_count_evt,
  // DMA channel 6 events
  input  wire logic        dma_ch6_abort_evt,
  input  wire logic        dma_ch6_overrun_evt,
  input  wire logic        dma_ch6_dest_count_evt,
  input  wire logic        dma_ch6_src_count_evt,
  // Serial unit 4 state
  input  wire logic [7:0]  serial4_irq_status,
  input  wire logic [7:0]  serial4_error_status,
  input  wire logic        serial4_tx_req,
  input  wire logic        serial4_rx_req,
  // Serial unit 5 state
  input  wire logic [7:0]  serial5_irq_status,
  input  wire logic [7:0]  serial5_error_status,
  input  wire logic        serial5_tx_req,
  input  wire logic        serial5_rx_req,
  // Other peripheral events
  input  wire logic        osc3_evt,
  input  wire logic        comparator2_evt,
  input  wire logic        logic_cell7_evt,
  input  wire logic        timer6_evt,
  input  wire logic        checksum_evt,
  input  wire logic        logic_cell8_evt,
  input  wire logic        nonvolatile_evt,
  // Flag images and interrupt
  output logic      [7:0]  irq_request_12,
  output logic      [7:0]  irq_request_13,
  output logic      [7:0]  irq_request_14,
  output logic      [7:0]  irq_request_15,
  output logic             irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam logic [31:0] HW_MAP = `HW_FLAG_MAP;

  logic [31:0] set_all;
  logic [31:0] wdata_all;
  logic [31:0] hw_flags;
  logic [31:0] image;
  logic [31:0] prev_image;
  logic [3:0]  wr_byte;
  logic [3:0]  byte_rise;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [3:0]  read_clear;
  logic        serial4_summary_flag;
  logic        serial4_error_flag;
  logic        serial4_tx_flag;
  logic        serial4_rx_flag;
  logic        serial5_summary_flag;
  logic        serial5_error_flag;
  logic        serial5_tx_flag;
  logic        serial5_rx_flag;
  logic        setup;
  logic        xfer_done;
  logic        wr_done;
  reg_sel_t    setup_sel;
  reg_sel_t    done_sel;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // ------------------------------------------------------------
  // Bus phase decode
  // ------------------------------------------------------------
  assign setup     = psel && !penable;
  assign xfer_done = psel && penable && pready;
  assign wr_done   = xfer_done && pwrite && pstrb[0];
  assign setup_sel = decode_addr(paddr);
  assign done_sel  = decode_addr(paddr);

  // Per-byte write strobes for the request registers
  assign wr_byte[0] = wr_done && (done_sel == SEL_REQ12);
  assign wr_byte[1] = wr_done && (done_sel == SEL_REQ13);
  assign wr_byte[2] = wr_done && (done_sel == SEL_REQ14);
  assign wr_byte[3] = wr_done && (done_sel == SEL_REQ15);

  // ------------------------------------------------------------
  // Hardware-set flags
  // ------------------------------------------------------------
  // Event image in register layout, bytes 15..12
  assign set_all = {
    4'h0, timer6_evt, checksum_evt, logic_cell8_evt, nonvolatile_evt,
    4'h0, osc3_evt, comparator2_evt, logic_cell7_evt, 1'b0,
    dma_ch6_abort_evt, dma_ch6_overrun_evt,
    dma_ch6_dest_count_evt, dma_ch6_src_count_evt, 4'h0,
    dma_ch5_abort_evt, dma_ch5_overrun_evt,
    dma_ch5_dest_count_evt, dma_ch5_src_count_evt, 4'h0
  };
  assign wdata_all = {4{pwdata[7:0]}};

  // One cell per hardware-set bit, unused positions read zero
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_flag
      if (HW_MAP[g]) begin : g_cell
        request_flag_cell u_cell (
          .pclk    (pclk),
          .presetn (presetn),
          .hw_set  (set_all[g]),
          .sw_wr   (wr_byte[g / 8]),
          .sw_data (wdata_all[g]),
          .flag    (hw_flags[g])
        );
      end else begin : g_none
        assign hw_flags[g] = 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Serial unit mirrors, never written by software
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial4_summary_flag <= 1'b0;
      serial4_error_flag   <= 1'b0;
      serial4_tx_flag      <= 1'b0;
      serial4_rx_flag      <= 1'b0;
    end else begin
      serial4_summary_flag <= |serial4_irq_status;
      serial4_error_flag   <= |serial4_error_status;
      serial4_tx_flag      <= serial4_tx_req;
      serial4_rx_flag      <= serial4_rx_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial5_summary_flag <= 1'b0;
      serial5_error_flag   <= 1'b0;
      serial5_tx_flag      <= 1'b0;
      serial5_rx_flag      <= 1'b0;
    end else begin
      serial5_summary_flag <= |serial5_irq_status;
      serial5_error_flag   <= |serial5_error_status;
      serial5_tx_flag      <= serial5_tx_req;
      serial5_rx_flag      <= serial5_rx_req;
    end
  end

  // ------------------------------------------------------------
  // Register images
  // ------------------------------------------------------------
  // Request 12 and 13 merge DMA cells with serial mirrors
  assign irq_request_12 = {hw_flags[7:4], serial4_summary_flag,
                           serial4_error_flag, serial4_tx_flag,
                           serial4_rx_flag};
  assign irq_request_13 = {hw_flags[15:12], serial5_summary_flag,
                           serial5_error_flag, serial5_tx_flag,
                           serial5_rx_flag};
  assign irq_request_14 = hw_flags[23:16];
  assign irq_request_15 = hw_flags[31:24];
  assign image = {irq_request_15, irq_request_14,
                  irq_request_13, irq_request_12};

  // ------------------------------------------------------------
  // Interrupt status: new flag in any request byte
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_image <= 32'h0000_0000;
    end else begin
      prev_image <= image;
    end
  end

  // Rise of any bit in each byte
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rise
      assign byte_rise[g] = |(image[8*g +: 8] & ~prev_image[8*g +: 8]);
    end
  endgenerate

  // Only bits that were returned by the read are cleared
  assign read_clear = (xfer_done && !pwrite && done_sel == SEL_STATUS)
                      ? prdata[3:0] : 4'h0;

  irq_status_mask u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .event_in   (byte_rise),
    .read_clear (read_clear),
    .mask_wr    (wr_done && done_sel == SEL_MASK),
    .mask_data  (pwdata[3:0]),
    .status     (status),
    .mask       (mask),
    .irq        (irq)
  );

  // ------------------------------------------------------------
  // APB read path and answer
  // ------------------------------------------------------------
  // Read data and error sampled in the setup cycle
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (setup_sel)
      SEL_REQ12:  next_prdata[7:0] = irq_request_12;
      SEL_REQ13:  next_prdata[7:0] = irq_request_13;
      SEL_REQ14:  next_prdata[7:0] = irq_request_14;
      SEL_REQ15:  next_prdata[7:0] = irq_request_15;
      SEL_STATUS: next_prdata[3:0] = status;
      SEL_MASK:   next_prdata[3:0] = mask;
      default:    next_pslverr     = 1'b1;
    endcase
  end

  // Answer registers, one access cycle with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && next_pslverr;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_req12_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    dma_ch5_abort_evt || dma_ch5_src_count_evt |=>
      (!$past(dma_ch5_abort_evt) || irq_request_12[`BIT_DMA_ABORT]) &&
      (!$past(dma_ch5_src_count_evt) || irq_request_12[`BIT_DMA_SRC]))
    else $error("DMA5 flags not in request 12 bits 7 and 4");

  a_ser4_summary: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq_request_12[`BIT_SER_SUMMARY] == $past(|serial4_irq_status))
    else $error("serial4 summary does not track its status");

  a_ser4_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    (serial4_error_status == 8'h00) [*2] |->
      !irq_request_12[`BIT_SER_ERROR])
    else $error("serial4 error flag set with error status clear");

  a_ser4_rdonly: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_byte[0] |=>
      irq_request_12[1:0] == $past({serial4_tx_req, serial4_rx_req}))
    else $error("software write reached serial4 tx or rx flag");

  a_req13_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {`IDX_REQ13, 2'b00} |=>
      pready && prdata == {24'h00_0000, $past(irq_request_13)})
    else $error("request 13 read returned wrong data");

  a_ser5_summary: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(irq_request_13[`BIT_SER_SUMMARY]) |->
      $past(serial5_irq_status) == 8'h00)
    else $error("serial5 summary cleared with status still set");

  a_ser5_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(irq_request_13[`BIT_SER_ERROR]) |->
      $past(serial5_error_status) == 8'h00)
    else $error("serial5 error cleared with error bits still set");

  a_ser5_rdonly: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_byte[1] |=>
      irq_request_13[1:0] == $past({serial5_tx_req, serial5_rx_req}))
    else $error("software write reached serial5 tx or rx flag");

  a_req14_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc3_evt |=> irq_request_14[3] ##0 irq_request_14[0] == 1'b0)
    else $error("request 14 oscillator flag misplaced");

  a_req15_layout: assert property (
    @(posedge pclk) disable iff (!presetn)
    timer6_evt || nonvolatile_evt |=>
      (!$past(timer6_evt) || irq_request_15[3]) &&
      (!$past(nonvolatile_evt) || irq_request_15[0]) &&
      irq_request_15[7:4] == 4'h0)
    else $error("request 15 flags misplaced");

  a_flag_reads_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {`IDX_REQ15, 2'b00} &&
      irq_request_15[2] |=> prdata[2])
    else $error("latched checksum flag did not read as one");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && decode_addr(paddr) == SEL_NONE |=> pready && pslverr)
    else $error("unmapped address not answered with an error");

  // Main scenarios
  c_dma_set_clear: cover property (
    @(posedge pclk) disable iff (!presetn)
    irq_request_12[`BIT_DMA_ABORT] ##1 wr_byte[0] ##1
      !irq_request_12[`BIT_DMA_ABORT]);

  c_set_and_clear: cover property (
    @(posedge pclk) disable iff (!presetn)
    wr_byte[0] && dma_ch5_overrun_evt && !pwdata[6]);

  c_irq_raised: cover property (
    @(posedge pclk) disable iff (!presetn) $rose(irq));

  c_status_read: cover property (
    @(posedge pclk) disable iff (!presetn) read_clear != 4'h0);

endmodule // periph_irq_flags

// *** rtl/request_flag_cell.sv ***
`timescale 1ns/1ns
`include "irq_flag_cfg.svh"

module request_flag_cell (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Hardware event and software write
  input  wire logic hw_set,
  input  wire logic sw_wr,
  input  wire logic sw_data,
  // Latched flag
  output logic      flag
);

  logic next_flag;

  // Set wins over a software clear
  always_comb begin
    next_flag = flag;
    if (sw_wr) begin
      next_flag = sw_data;
    end
    if (hw_set) begin
      next_flag = 1'b1;
    end
  end

  // Flag storage, only reset or a write may clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_event_sets_flag: assert property (
    @(posedge pclk) disable iff (!presetn) hw_set |=> flag)
    else $error("flag not set after hardware event");

  a_no_self_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(flag) |-> $past(sw_wr) && !$past(sw_data))
    else $error("flag cleared without a software write");

  a_set_beats_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    hw_set && sw_wr && !sw_data |=> flag ##1 (flag || $past(sw_wr)))
    else $error("simultaneous set and clear lost the event");

endmodule // request_flag_cell
